// >>> common/trs_pkg.sv
// package: shared constants, states and carriers of the trace record store
package trs_pkg;
    // buffer-management area field offsets from the save area pointer
    localparam logic [31:0] TRS_OFS_BR_BASE = 32'h0000_0000;
    localparam logic [31:0] TRS_OFS_BR_IDX = 32'h0000_0004;
    localparam logic [31:0] TRS_OFS_BR_MAX = 32'h0000_0008;
    localparam logic [31:0] TRS_OFS_BR_THR = 32'h0000_000C;
    localparam logic [31:0] TRS_OFS_SM_BASE = 32'h0000_0010;
    localparam logic [31:0] TRS_OFS_SM_IDX = 32'h0000_0014;
    localparam logic [31:0] TRS_OFS_SM_MAX = 32'h0000_0018;
    localparam logic [31:0] TRS_OFS_SM_THR = 32'h0000_001C;
    localparam logic [31:0] TRS_OFS_RLD_LO = 32'h0000_0020;
    localparam logic [31:0] TRS_OFS_RLD_HI = 32'h0000_0024;
    // record geometry
    localparam logic [31:0] TRS_BR_REC_BYTES = 32'h0000_000C;
    localparam logic [31:0] TRS_SM_REC_BYTES = 32'h0000_0028;
    localparam logic [3:0] TRS_BR_WORDS = 4'h3;
    localparam logic [3:0] TRS_SM_WORDS = 4'hA;
    localparam int TRS_REC_MAX_WORDS = 10;
    localparam int TRS_PRED_BIT = 4;
    localparam int TRS_RELOAD_W = 40;
    // sampling record word slots (byte offset / 4)
    localparam logic [3:0] TRS_SM_FLAGS_W = 4'h0;
    localparam logic [3:0] TRS_SM_LIP_W = 4'h1;
    localparam logic [3:0] TRS_SM_GPR0_W = 4'h2;
    localparam logic [3:0] TRS_SM_SP_W = 4'h9;
    // reset value and fixed absent-flag values
    localparam logic TRS_REC_EN_RST = 1'b0;
    localparam logic TRS_BR_ABSENT = 1'b0;
    localparam logic TRS_SM_ABSENT = 1'b0;

    typedef enum logic [2:0] {
        TRS_IDLE = 3'b000,
        TRS_RD_IDX = 3'b001,
        TRS_RD_MAX = 3'b010,
        TRS_RD_THR = 3'b011,
        TRS_WR_REC = 3'b100,
        TRS_WR_IDX = 3'b101,
        TRS_RD_RLO = 3'b110,
        TRS_RD_RHI = 3'b111
    } trs_state_t;

    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } trs_mem_req_t;

    typedef struct packed {
        logic [31:0] from_lin;
        logic [31:0] to_lin;
        logic predicted;
    } trs_branch_t;

    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] lin_ip;
        logic [7:0][31:0] gpr;
        logic [4:0] ctr_id;
    } trs_sample_t;
endpackage

// >>> core/trs_store.sv
// trace record store: writes branch and sampling records to memory
`timescale 1ns/10ps
// Function
// - entering system management mode stops all record writes.
// - machine check disables recording; reset and init clear the enable.
// - real address mode does not suppress recording.
// - two read-only flags report branch or sampling storing absent.
// - management area located by the save area pointer.
// - branch index gives next branch record address; device writes there.
// - interrupt when the branch record at threshold address is written.
// - sampling index gives next sampling record address; written there.
// - interrupt when the sampling record at threshold is written.
// - after a sampling record, overflowed counter reloads 40-bit value.
// - branch record is twelve bytes: source and target linear address.
// - bit four of third branch field marks predicted branch.
// - sampling record: flags, linear_instruction_pointer, eight registers to 24H.
// - sampled registers taken as presented at instruction start.
// - ip field holds instruction pointer as a linear address.
// - branch enable set: record every taken branch, interrupt, exception.
// - counter overflow in sampling mode stores a record, then reloads.
module trs_store
    import trs_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_init,
    input wire logic i_machine_check,
    input wire logic i_system_management_mode,
    input wire logic i_record_arm,
    input wire logic i_branch_trace_en,
    input wire logic [31:0] i_save_area_pointer,
    input wire logic i_branch_valid,
    input wire trs_branch_t i_branch,
    output logic o_branch_ready,
    input wire logic i_sample_valid,
    input wire trs_sample_t i_sample,
    output logic o_sample_ready,
    output logic o_mem_valid,
    output trs_mem_req_t o_mem_req,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    output logic o_reload_valid,
    output logic [4:0] o_reload_ctr,
    output logic [TRS_RELOAD_W-1:0] o_reload_value,
    output logic o_perf_monitor_interrupt,
    output logic o_branch_full,
    output logic o_sample_full,
    output logic o_recording_en,
    output logic o_branch_trace_absent_flag,
    output logic o_event_sampling_absent_flag
);
    ////////////////////////////////////////////////////////////////////////
    // state
    trs_state_t state_q, state_d;
    logic rec_en_q, rec_en_d;
    logic is_sm_q, is_sm_d;
    logic [3:0] wcnt_q, wcnt_d;
    logic [31:0] idx_q, idx_d;
    logic [31:0] thr_q, thr_d;
    logic [31:0] rld_lo_q, rld_lo_d;
    logic [31:0] rec_q [TRS_REC_MAX_WORDS];
    logic [31:0] rec_d [TRS_REC_MAX_WORDS];
    logic [4:0] ctr_q, ctr_d;
    logic br_full_q, br_full_d;
    logic sm_full_q, sm_full_d;
    logic pmi_q, pmi_d;
    logic rld_v_q, rld_v_d;
    logic [TRS_RELOAD_W-1:0] rld_q, rld_d;
    logic kill, active, take_sm, take_br, hs;
    logic [3:0] last_w;
    logic [31:0] rec_size;

    ////////////////////////////////////////////////////////////////////////
    // gating and request decode
    // real address mode is deliberately not among the gates
    assign kill = i_init | i_machine_check | i_system_management_mode;
    assign active = rec_en_q & ~kill;
    assign take_sm = active & i_sample_valid & ~TRS_SM_ABSENT;
    assign take_br = active & i_branch_valid & i_branch_trace_en
        & ~TRS_BR_ABSENT & ~i_sample_valid;
    assign o_sample_ready = (state_q == TRS_IDLE) & active & ~TRS_SM_ABSENT;
    assign o_branch_ready = (state_q == TRS_IDLE) & active
        & i_branch_trace_en & ~TRS_BR_ABSENT & ~i_sample_valid;
    assign last_w = is_sm_q ? TRS_SM_WORDS - 4'h1 : TRS_BR_WORDS - 4'h1;
    assign rec_size = is_sm_q ? TRS_SM_REC_BYTES : TRS_BR_REC_BYTES;
    assign o_mem_valid = (state_q != TRS_IDLE) & ~kill;
    assign hs = o_mem_valid & i_mem_ack;

    always_comb begin
        o_mem_req = '0;
        unique case (state_q)
            TRS_IDLE: begin
                o_mem_req = '0;
            end
            TRS_RD_IDX: begin
                o_mem_req.addr = i_save_area_pointer
                    + (is_sm_q ? TRS_OFS_SM_IDX : TRS_OFS_BR_IDX);
            end
            TRS_RD_MAX: begin
                o_mem_req.addr = i_save_area_pointer
                    + (is_sm_q ? TRS_OFS_SM_MAX : TRS_OFS_BR_MAX);
            end
            TRS_RD_THR: begin
                o_mem_req.addr = i_save_area_pointer
                    + (is_sm_q ? TRS_OFS_SM_THR : TRS_OFS_BR_THR);
            end
            TRS_WR_REC: begin
                o_mem_req.we = 1'b1;
                o_mem_req.addr = idx_q + {26'h0, wcnt_q, 2'b00};
                o_mem_req.wdata = rec_q[wcnt_q];
            end
            TRS_WR_IDX: begin
                o_mem_req.we = 1'b1;
                o_mem_req.addr = i_save_area_pointer
                    + (is_sm_q ? TRS_OFS_SM_IDX : TRS_OFS_BR_IDX);
                o_mem_req.wdata = idx_q + rec_size;
            end
            TRS_RD_RLO: begin
                o_mem_req.addr = i_save_area_pointer + TRS_OFS_RLD_LO;
            end
            TRS_RD_RHI: begin
                o_mem_req.addr = i_save_area_pointer + TRS_OFS_RLD_HI;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_d = state_q;
        rec_en_d = rec_en_q;
        is_sm_d = is_sm_q;
        wcnt_d = wcnt_q;
        idx_d = idx_q;
        thr_d = thr_q;
        rld_lo_d = rld_lo_q;
        rec_d = rec_q;
        ctr_d = ctr_q;
        br_full_d = br_full_q;
        sm_full_d = sm_full_q;
        pmi_d = 1'b0;
        rld_v_d = 1'b0;
        rld_d = rld_q;
        if (i_record_arm) begin
            rec_en_d = 1'b1;
        end
        if (i_init | i_machine_check) begin
            rec_en_d = 1'b0;
        end
        if (kill) begin
            state_d = TRS_IDLE;
        end else begin
            unique case (state_q)
                TRS_IDLE: begin
                    wcnt_d = 4'h0;
                    if (take_sm) begin
                        is_sm_d = 1'b1;
                        ctr_d = i_sample.ctr_id;
                        rec_d[TRS_SM_FLAGS_W] = i_sample.flags;
                        rec_d[TRS_SM_LIP_W] = i_sample.lin_ip;
                        for (int g = 0; g < 8; g++) begin
                            rec_d[int'(TRS_SM_GPR0_W) + g] =
                                i_sample.gpr[7 - g];
                        end
                        state_d = TRS_RD_IDX;
                    end else if (take_br) begin
                        is_sm_d = 1'b0;
                        rec_d[0] = i_branch.from_lin;
                        rec_d[1] = i_branch.to_lin;
                        rec_d[2] = '0;
                        rec_d[2][TRS_PRED_BIT] = i_branch.predicted;
                        state_d = TRS_RD_IDX;
                    end
                end
                TRS_RD_IDX: begin
                    if (hs) begin
                        idx_d = i_mem_rdata;
                        state_d = TRS_RD_MAX;
                    end
                end
                TRS_RD_MAX: begin
                    if (hs) begin
                        if (idx_q >= i_mem_rdata) begin
                            br_full_d = br_full_q | ~is_sm_q;
                            sm_full_d = sm_full_q | is_sm_q;
                            state_d = TRS_IDLE;
                        end else begin
                            state_d = TRS_RD_THR;
                        end
                    end
                end
                TRS_RD_THR: begin
                    if (hs) begin
                        thr_d = i_mem_rdata;
                        state_d = TRS_WR_REC;
                    end
                end
                TRS_WR_REC: begin
                    if (hs) begin
                        wcnt_d = wcnt_q + 4'h1;
                        if (wcnt_q == last_w) begin
                            state_d = TRS_WR_IDX;
                        end
                    end
                end
                TRS_WR_IDX: begin
                    if (hs) begin
                        pmi_d = (idx_q == thr_q);
                        br_full_d = br_full_q & is_sm_q;
                        sm_full_d = sm_full_q & ~is_sm_q;
                        state_d = is_sm_q ? TRS_RD_RLO : TRS_IDLE;
                    end
                end
                TRS_RD_RLO: begin
                    if (hs) begin
                        rld_lo_d = i_mem_rdata;
                        state_d = TRS_RD_RHI;
                    end
                end
                TRS_RD_RHI: begin
                    if (hs) begin
                        rld_d = {i_mem_rdata[7:0], rld_lo_q};
                        rld_v_d = 1'b1;
                        state_d = TRS_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= TRS_IDLE;
            rec_en_q <= TRS_REC_EN_RST;
            is_sm_q <= 1'b0;
            wcnt_q <= 4'h0;
            idx_q <= '0;
            thr_q <= '0;
            rld_lo_q <= '0;
            for (int i = 0; i < TRS_REC_MAX_WORDS; i++) begin
                rec_q[i] <= '0;
            end
            ctr_q <= '0;
            br_full_q <= 1'b0;
            sm_full_q <= 1'b0;
            pmi_q <= 1'b0;
            rld_v_q <= 1'b0;
            rld_q <= '0;
        end else begin
            state_q <= state_d;
            rec_en_q <= rec_en_d;
            is_sm_q <= is_sm_d;
            wcnt_q <= wcnt_d;
            idx_q <= idx_d;
            thr_q <= thr_d;
            rld_lo_q <= rld_lo_d;
            rec_q <= rec_d;
            ctr_q <= ctr_d;
            br_full_q <= br_full_d;
            sm_full_q <= sm_full_d;
            pmi_q <= pmi_d;
            rld_v_q <= rld_v_d;
            rld_q <= rld_d;
        end
    end

    assign o_reload_valid = rld_v_q;
    assign o_reload_ctr = ctr_q;
    assign o_reload_value = rld_q;
    assign o_perf_monitor_interrupt = pmi_q;
    assign o_branch_full = br_full_q;
    assign o_sample_full = sm_full_q;
    assign o_recording_en = rec_en_q;
    assign o_branch_trace_absent_flag = TRS_BR_ABSENT;
    assign o_event_sampling_absent_flag = TRS_SM_ABSENT;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    a_smm_no_write: assert property (
        i_system_management_mode |-> !o_mem_valid ##1 state_q == TRS_IDLE)
        else $error("memory access during system management mode");
    a_mc_clears_en: assert property (
        (i_machine_check | i_init) |=> !o_recording_en [*1])
        else $error("recording still enabled after disable event");
    a_absent_flags: assert property (
        o_branch_trace_absent_flag == TRS_BR_ABSENT
        && o_event_sampling_absent_flag == TRS_SM_ABSENT)
        else $error("capability flag changed");
    a_area_idx_addr: assert property (
        state_q == TRS_RD_IDX && o_mem_valid |-> o_mem_req.addr ==
        i_save_area_pointer + (is_sm_q ? TRS_OFS_SM_IDX : TRS_OFS_BR_IDX))
        else $error("index fetch away from management area");
    a_index_advance: assert property (
        state_q == TRS_WR_IDX && o_mem_valid |-> o_mem_req.we &&
        o_mem_req.wdata - idx_q == (is_sm_q ? 32'h28 : 32'h0C))
        else $error("index not advanced by one record");
    a_pred_bit: assert property (
        take_br && state_q == TRS_IDLE |=>
        rec_q[2][4] == $past(i_branch.predicted) && rec_q[2][3:0] == 4'h0)
        else $error("predicted bit misplaced");
    a_thr_irq: assert property (
        state_q == TRS_WR_IDX && hs && idx_q == thr_q |=>
        o_perf_monitor_interrupt ##1 !o_perf_monitor_interrupt)
        else $error("threshold interrupt missing or stuck");
    a_full_stop: assert property (
        state_q == TRS_RD_MAX && hs && i_mem_rdata <= idx_q |=>
        state_q == TRS_IDLE && (o_branch_full | o_sample_full))
        else $error("record written at absolute maximum");
    a_reload_val: assert property (
        state_q == TRS_RD_RHI && hs |=> o_reload_valid &&
        o_reload_value[39:32] == $past(i_mem_rdata[7:0]))
        else $error("reload value wrong");
    a_rec_words: assert property (
        state_q == TRS_WR_REC && hs && !is_sm_q && wcnt_q == 4'h2 |=>
        state_q == TRS_WR_IDX)
        else $error("branch record not three words");
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the trace record store
`timescale 1ns/10ps
module tb_top
    import trs_pkg::*;
;
    typedef struct packed {
        logic pred;
        logic wr;
        logic full;
        logic irq;
    } trs_row_t;
    localparam logic [31:0] AREA = 32'h0000_1000;
    localparam logic [31:0] BB = 32'h0000_2000;
    localparam logic [31:0] SB = 32'h0000_3000;
    trs_row_t rows [5] = '{4'hC, 4'h4, 4'hD, 4'h4, 4'h2};
    logic clk = 1'b0, rst = 1'b1, init = 1'b0, mc = 1'b0, system_management_mode = 1'b0;
    logic arm = 1'b0, slow = 1'b0, bv = 1'b0, sv = 1'b0, bten = 1'b1;
    trs_branch_t br = '0;
    trs_sample_t sm = '0;
    trs_mem_req_t mreq;
    logic brdy, srdy, mv, mack, rv, perf_monitor_interrupt, bfull, sfull, ren, babs, sabs;
    logic [31:0] mrd, a;
    logic [4:0] rctr;
    logic [39:0] rval;
    int bad_count = 0, num_checks = 0, pmi_cnt = 0, rld_cnt = 0;
    int smm_hits = 0, cyc = 0, exp_pmi = 0;
    ////////////////////////////////////////////////////////////////////
    trs_store dut_u (.i_ref_clk(clk), .i_rst(rst), .i_init(init),
        .i_machine_check(mc), .i_system_management_mode(system_management_mode),
        .i_record_arm(arm), .i_branch_trace_en(bten),
        .i_save_area_pointer(AREA), .i_branch_valid(bv), .i_branch(br),
        .o_branch_ready(brdy), .i_sample_valid(sv), .i_sample(sm),
        .o_sample_ready(srdy), .o_mem_valid(mv), .o_mem_req(mreq),
        .i_mem_ack(mack), .i_mem_rdata(mrd), .o_reload_valid(rv),
        .o_reload_ctr(rctr), .o_reload_value(rval),
        .o_perf_monitor_interrupt(perf_monitor_interrupt), .o_branch_full(bfull),
        .o_sample_full(sfull), .o_recording_en(ren),
        .o_branch_trace_absent_flag(babs),
        .o_event_sampling_absent_flag(sabs));
    trs_mem_model mem_u (.i_ref_clk(clk), .i_rst(rst), .i_valid(mv),
        .i_req(mreq), .i_slow(slow), .o_ack(mack), .o_rdata(mrd));
    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        cyc++;
        if (perf_monitor_interrupt === 1'b1) pmi_cnt++;
        if (rv === 1'b1) rld_cnt++;
        if (system_management_mode && mv !== 1'b0) smm_hits++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [39:0] e,
                       input logic [39:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic send(input logic smp);
        int n;
        if (smp) sv = 1'b1;
        else bv = 1'b1;
        #1;
        for (n = 0; n < 50 && !(smp ? srdy : brdy); n++) begin
            @(posedge clk);
            #2;
        end
        chk("event_ready", 40'h1, smp ? srdy : brdy);
        tick(1);
        bv = 1'b0;
        sv = 1'b0;
    endtask
    task automatic wait_done();
        int n, idle;
        idle = 0;
        for (n = 0; n < 300 && idle < 3; n++) begin
            tick(1);
            idle = (mv === 1'b0) ? idle + 1 : 0;
        end
        chk("record_done", 40'h3, idle);
    endtask
    task automatic refused();
        bv = 1'b1;
        repeat (3) begin
            tick(1);
            chk("branch_ready", 40'h0, brdy);
        end
        bv = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        tick(10);
        chk("reset_mem_valid", 40'h0, mv);
        chk("reset_rec_en", 40'h0, ren);
        rst = 1'b0;
        chk("br_absent", TRS_BR_ABSENT, babs);
        chk("sm_absent", TRS_SM_ABSENT, sabs);
        mem_u.poke(AREA, BB);
        mem_u.poke(AREA + 32'h4, BB);
        mem_u.poke(AREA + 32'h8, BB + 32'd37);
        mem_u.poke(AREA + 32'hC, BB + 32'd24);
        mem_u.poke(AREA + 32'h10, SB);
        mem_u.poke(AREA + 32'h14, SB);
        mem_u.poke(AREA + 32'h18, SB + 32'd81);
        mem_u.poke(AREA + 32'h1C, SB);
        mem_u.poke(AREA + 32'h20, 32'h1234_5678);
        mem_u.poke(AREA + 32'h24, 32'hFFFF_FFAB);
        tick(1);
        pulse(arm);
        for (int i = 0; i < 5; i++) begin
            a = BB + 32'd12 * i;
            br = '{32'h4000_0000 + i, 32'h5000_0000 + i, rows[i].pred};
            send(1'b0);
            wait_done();
            if (rows[i].irq) exp_pmi++;
            if (rows[i].wr) begin
                chk("br_from", br.from_lin, mem_u.peek(a));
                chk("br_to", br.to_lin, mem_u.peek(a + 32'h4));
                chk("br_pred", {rows[i].pred, 4'h0},
                    mem_u.peek(a + 32'h8));
            end
            chk("br_idx", BB + 32'd12 * (i + rows[i].wr),
                mem_u.peek(AREA + 32'h4));
            chk("br_full", rows[i].full, bfull);
            chk("br_pmi", exp_pmi, pmi_cnt);
        end
        mem_u.poke(AREA + 32'h4, BB);
        br = '{32'h4100_0000, 32'h5100_0000, 1'b1};
        send(1'b0);
        tick(3);
        pulse(init);
        wait_done();
        chk("init_idx", BB, mem_u.peek(AREA + 32'h4));
        chk("init_rec_en", 40'h0, ren);
        arm = 1'b1;
        init = 1'b1;
        tick(1);
        {arm, init} = 2'b00;
        chk("arm_init_en", 40'h0, ren);
        pulse(arm);
        send(1'b0);
        wait_done();
        chk("rearm_idx", BB + 32'd12, mem_u.peek(AREA + 32'h4));
        chk("rearm_full", 40'h0, bfull);
        bten = 1'b0;
        refused();
        bten = 1'b1;
        pulse(mc);
        chk("mc_rec_en", 40'h0, ren);
        chk("mc_smp_ready", 40'h0, srdy);
        refused();
        pulse(arm);
        system_management_mode = 1'b1;
        refused();
        chk("smm_smp_ready", 40'h0, srdy);
        system_management_mode = 1'b0;
        chk("smm_traffic", 40'h0, smm_hits);
        slow = 1'b1;
        // system management mode cuts a record in flight
        send(1'b0);
        tick(2);
        system_management_mode = 1'b1;
        tick(2);
        system_management_mode = 1'b0;
        wait_done();
        chk("smm_abort_hits", 40'h0, smm_hits);
        chk("smm_abort_idx", BB + 32'd12, mem_u.peek(AREA + 32'h4));
        sm.flags = 32'h0000_0246;
        sm.lin_ip = 32'h0040_1000;
        sm.ctr_id = 5'h05;
        for (int k = 0; k < 8; k++) sm.gpr[k] = 32'hA000_0000 + k;
        send(1'b1);
        wait_done();
        exp_pmi++;
        chk("sm_flags", sm.flags, mem_u.peek(SB));
        chk("sm_lip", sm.lin_ip, mem_u.peek(SB + 32'h4));
        for (int k = 0; k < 8; k++) begin
            chk("sm_gpr", sm.gpr[7 - k],
                mem_u.peek(SB + 32'h8 + 4 * k));
        end
        chk("sm_idx", SB + 32'd40, mem_u.peek(AREA + 32'h14));
        chk("sm_pmi", exp_pmi, pmi_cnt);
        chk("rld_cnt", 40'h1, rld_cnt);
        chk("rld_val", 40'hAB_1234_5678, rval);
        chk("rld_ctr", 5'h05, rctr);
        chk("sm_not_full", 40'h0, sfull);
        // sampling index already past the maximum: dropped, no reload
        mem_u.poke(AREA + 32'h14, SB + 32'd120);
        send(1'b1);
        wait_done();
        chk("sm_full", 40'h1, sfull);
        chk("sm_stop_idx", SB + 32'd120, mem_u.peek(AREA + 32'h14));
        chk("sm_stop_rld", 40'h1, rld_cnt);
        // mid-run reset clears enable and full flags
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        chk("rst_sm_full", 40'h0, sfull);
        chk("rst_rec_en", 40'h0, ren);
        test_done();
    end
endmodule

// >>> tb/trs_mem_model.sv
// memory partner holding the save area and both record buffers
`timescale 1ns/10ps
module trs_mem_model
    import trs_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire trs_mem_req_t i_req,
    input wire logic i_slow,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [31:0] mem [logic [29:0]];
    logic [1:0] wait_q;
    logic [31:0] last_q;
    function automatic logic [31:0] peek(input logic [31:0] a);
        return mem.exists(a[31:2]) ? mem[a[31:2]] : 32'h0000_0000;
    endfunction
    task automatic poke(input logic [31:0] a, input logic [31:0] d);
        mem[a[31:2]] = d;
    endtask
    // slow mode holds ack back two cycles
    assign o_ack = i_valid && (!i_slow || wait_q == 2'h2);
    // idle data bus shows the inverse of the last value
    always @* begin
        o_rdata = (o_ack && !i_req.we) ? peek(i_req.addr) : ~last_q;
    end
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_q <= 2'h0;
            last_q <= 32'h0000_0000;
        end else if (o_ack) begin
            wait_q <= 2'h0;
            last_q <= i_req.we ? i_req.wdata : o_rdata;
            if (i_req.we) mem[i_req.addr[31:2]] = i_req.wdata;
        end else if (i_valid) begin
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule
